// *** pkg/ftm_consts.svh ***
// Purpose: shared constants of the fifo pair block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef FTM_CONSTS_SVH
`define FTM_CONSTS_SVH

`define FTM_LW         36
`define FTM_HW         18
`define FTM_BW         9
`define FTM_DEPTH      16384
`define FTM_PRESET     8
`define FTM_OFS_E1     0
`define FTM_OFS_E2     1
`define FTM_OFS_F1     2
`define FTM_OFS_F2     3
`define FTM_OFS_NUM    4
`define FTM_LAST_WORD  2'h1
`define FTM_LAST_BYTE  2'h3
`define FTM_HW_ZERO    18'h00000
`define FTM_BW_ZERO    9'h000

`endif

// *** pkg/ftm_pkg.sv ***
// Purpose: types shared by the fifo pair block
// Assumes: ftm_consts.svh provides the widths
// Notes:   pins pass one synchroniser as one packed word
`include "ftm_consts.svh"

package ftm_pkg;

  typedef struct packed {
    logic                clk;
    logic                cs_n;
    logic                dir;
    logic                strobe;
    logic                mail;
    logic                prog;
    logic [1:0]          prog_idx;
    logic                ser_en;
    logic                ser_dat;
    logic [`FTM_LW-1:0]  data;
  } ftm_a_in_s;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic ren;
    logic mail;
  } ftm_b_in_s;

  typedef struct packed {
    logic                clk;
    logic                wen;
    logic                mail;
    logic [`FTM_HW-1:0]  data;
  } ftm_c_in_s;

  typedef struct packed {
    logic mr1_n;
    logic mr2_n;
    logic endian;
    logic bsize;
    logic csize;
  } ftm_cfg_in_s;

  typedef struct packed {
    ftm_a_in_s   a;
    ftm_b_in_s   b;
    ftm_c_in_s   c;
    ftm_cfg_in_s cfg;
  } ftm_pins_s;

  typedef struct packed {
    logic stage;
    logic flag;
  } ftm_flag_s;

endpackage : ftm_pkg

// *** src/ftm_fifo_pair.sv ***
// Purpose: flags, mailboxes and bus sizing of a triple-port fifo pair
// Assumes: port clocks much slower than i_clk
// Notes:   width select high means byte width; endian high means msb first
// Functional notes
// - nearly-empty flags follow pointer compare on reading port edges.
// - nearly-empty low at fill up to offset, high at offset plus one.
// - word in output register is not counted as fill.
// - nearly-empty rises on second reading-port edge after the filling write.
// - nearly-full flags follow pointer compare on writing port edges.
// - nearly-full low at fill >= depth-offset, high at <= depth-offset-1.
// - nearly-full rises on second writing-port edge after the draining read.
// - four offsets: preset in reset, written from port A, or shifted serially.
// - two 18-bit mail registers, A to B and C to A, bypass the queues.
// - driven data shows fifo output, or mail when mail select high.
// - port A mail write loads A-to-B mail, A0-A17 word or A0-A8 byte.
// - port C mail write loads C-to-A mail, C0-C17 word or C0-C8 byte.
// - mail write drives its flag low; further writes ignored while low.
// - port B mail read sets A-to-B flag high, data on B lanes.
// - port A mail read sets C-to-A flag high, data on A18 upward.
// - mail contents survive reads; no endian reordering on mail.
// - ports B and C each choose word or byte width by static inputs.
// - width and endian choices take effect as master reset ends.
// - endian sampled at master reset release, applies to ports B and C.
// - memories hold 36-bit long words; sizing after fifo1, before fifo2.
// - port C pieces gather in a register; commit on last piece.
// - port B holds a read long word and hands out remaining pieces.
`timescale 1ns/1ps
`include "ftm_consts.svh"

module ftm_fifo_pair #(
  parameter int DEPTH  = `FTM_DEPTH,
  parameter int PRESET = `FTM_PRESET
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_port_a_clock,
  input  wire logic                 i_port_a_chip_select_n,
  input  wire logic                 i_port_a_direction,
  input  wire logic                 i_port_a_strobe_on,
  input  wire logic                 i_port_a_mail_select,
  input  wire logic                 i_port_a_prog_enable,
  input  wire logic [1:0]           i_port_a_prog_index,
  input  wire logic                 i_serial_enable,
  input  wire logic                 i_serial_data,
  input  wire logic [`FTM_LW-1:0]   i_port_a_data,
  output logic      [`FTM_LW-1:0]   o_port_a_data,
  output logic                      o_port_a_data_oe,
  input  wire logic                 i_port_b_clock,
  input  wire logic                 i_port_b_chip_select_n,
  input  wire logic                 i_port_b_read_strobe,
  input  wire logic                 i_port_b_mail_select,
  output logic      [`FTM_HW-1:0]   o_port_b_data,
  output logic                      o_port_b_data_oe,
  input  wire logic                 i_port_c_clock,
  input  wire logic                 i_port_c_write_strobe,
  input  wire logic                 i_port_c_mail_select,
  input  wire logic [`FTM_HW-1:0]   i_port_c_data,
  input  wire logic                 i_port_b_width_sel,
  input  wire logic                 i_port_c_width_sel,
  input  wire logic                 i_endian_select,
  input  wire logic                 i_fifo1_master_reset_n,
  input  wire logic                 i_fifo2_master_reset_n,
  output logic                      o_fifo1_nearly_empty_flag,
  output logic                      o_fifo2_nearly_empty_flag,
  output logic                      o_fifo1_nearly_full_flag,
  output logic                      o_fifo2_nearly_full_flag,
  output logic                      o_fifo1_room_flag,
  output logic                      o_fifo2_room_flag,
  output logic                      o_mail_ab_full_n,
  output logic                      o_mail_ca_full_n
);
  import ftm_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  typedef struct packed {
    logic [2:0]                clk_prev;
    logic [1:0]                mr_prev;
    logic                      endian;
    logic                      bsize;
    logic                      csize;
    logic [PW-1:0]             w1;
    logic [PW-1:0]             r1;
    logic [PW-1:0]             w2;
    logic [PW-1:0]             r2;
    logic                      room1;
    logic                      room2;
    logic                      mab_full_n;
    logic                      mca_full_n;
    logic [`FTM_HW-1:0]        mab;
    logic [`FTM_HW-1:0]        mca;
    logic [`FTM_LW-1:0]        b_hold;
    logic [1:0]                b_idx;
    logic [`FTM_LW-1:0]        c_asm;
    logic [1:0]                c_idx;
    logic [`FTM_LW-1:0]        a_out;
    logic [`FTM_HW-1:0]        b_out;
    logic [`FTM_LW-1:0]        a_dout;
    logic [`FTM_HW-1:0]        b_dout;
    logic                      a_oe;
    logic                      b_oe;
    logic [`FTM_OFS_NUM-1:0][AW-1:0] ofs;
  } ftm_state_s;

  ftm_state_s          q_q;
  ftm_state_s          q_d;
  ftm_pins_s           pin_raw;
  ftm_pins_s           p;
  logic [`FTM_LW-1:0]  mem1 [DEPTH];
  logic [`FTM_LW-1:0]  mem2 [DEPTH];
  logic [`FTM_LW-1:0]  mem1_rd;
  logic [`FTM_LW-1:0]  mem2_rd;
  logic                m1_we;
  logic                m2_we;
  logic [`FTM_LW-1:0]  m2_wdata;
  logic [PW-1:0]       cnt1;
  logic [PW-1:0]       cnt2;
  logic [3:0]          flag_edge;
  logic [3:0]          flag_lvl;
  logic [3:0]          flag_rst_n;
  logic [3:0]          flag_out;

  // piece k of a long word on an 18-bit lane
  function automatic logic [`FTM_HW-1:0] pick(input logic [`FTM_LW-1:0] lw,
                                              input logic byte_m, input logic big,
                                              input logic [1:0] k);
    logic [1:0] lane;
    lane = big ? (`FTM_LAST_BYTE - k) : k;
    if (byte_m) begin
      pick = {`FTM_BW_ZERO, lw[`FTM_BW*lane +: `FTM_BW]};
    end else begin
      pick = lw[`FTM_HW*(k[0] ^ big) +: `FTM_HW];
    end
  endfunction : pick

  // put piece k into its slot of the long word
  function automatic logic [`FTM_LW-1:0] place(input logic [`FTM_LW-1:0] lw,
                                               input logic [`FTM_HW-1:0] pc,
                                               input logic byte_m, input logic big,
                                               input logic [1:0] k);
    logic [1:0]          lane;
    logic [`FTM_LW-1:0]  r;
    lane = big ? (`FTM_LAST_BYTE - k) : k;
    r    = lw;
    if (byte_m) begin
      r[`FTM_BW*lane +: `FTM_BW] = pc[`FTM_BW-1:0];
    end else begin
      r[`FTM_HW*(k[0] ^ big) +: `FTM_HW] = pc;
    end
    place = r;
  endfunction : place

  assign pin_raw.a = '{clk: i_port_a_clock, cs_n: i_port_a_chip_select_n,
                       dir: i_port_a_direction, strobe: i_port_a_strobe_on,
                       mail: i_port_a_mail_select, prog: i_port_a_prog_enable,
                       prog_idx: i_port_a_prog_index, ser_en: i_serial_enable,
                       ser_dat: i_serial_data, data: i_port_a_data};
  assign pin_raw.b = '{clk: i_port_b_clock, cs_n: i_port_b_chip_select_n,
                       ren: i_port_b_read_strobe, mail: i_port_b_mail_select};
  assign pin_raw.c = '{clk: i_port_c_clock, wen: i_port_c_write_strobe,
                       mail: i_port_c_mail_select, data: i_port_c_data};
  assign pin_raw.cfg = '{mr1_n: i_fifo1_master_reset_n, mr2_n: i_fifo2_master_reset_n,
                         endian: i_endian_select, bsize: i_port_b_width_sel,
                         csize: i_port_c_width_sel};

  ftm_sync #(.W($bits(ftm_pins_s))) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (pin_raw),
    .o_q    (p)
  );

  assign mem1_rd = mem1[q_q.r1[AW-1:0]];
  assign mem2_rd = mem2[q_q.r2[AW-1:0]];
  assign cnt1    = q_q.w1 - q_q.r1;
  assign cnt2    = q_q.w2 - q_q.r2;

  always_comb begin
    logic       ea;
    logic       eb;
    logic       ec;
    logic       a_wr;
    logic       a_rd;
    logic       b_rd;
    logic       c_wr;
    logic       run1;
    logic       run2;
    logic [1:0] b_last;
    logic [1:0] c_last;
    q_d      = q_q;
    m1_we    = 1'b0;
    m2_we    = 1'b0;
    m2_wdata = q_q.c_asm;
    // edges may be one i_clk late
    ea     = p.a.clk & ~q_q.clk_prev[2];
    eb     = p.b.clk & ~q_q.clk_prev[1];
    ec     = p.c.clk & ~q_q.clk_prev[0];
    q_d.clk_prev = {p.a.clk, p.b.clk, p.c.clk};
    q_d.mr_prev  = {p.cfg.mr1_n, p.cfg.mr2_n};
    run1   = p.cfg.mr1_n;
    run2   = p.cfg.mr2_n;
    // mail selects idle in master reset
    a_wr   = ea & ~p.a.cs_n & p.a.dir & p.a.strobe;
    a_rd   = ea & ~p.a.cs_n & ~p.a.dir & p.a.strobe;
    b_rd   = eb & ~p.b.cs_n & p.b.ren & run1;
    c_wr   = ec & p.c.wen & run2;
    b_last = q_q.bsize ? `FTM_LAST_BYTE : `FTM_LAST_WORD;
    c_last = q_q.csize ? `FTM_LAST_BYTE : `FTM_LAST_WORD;

    // latched at master reset release
    if (p.cfg.mr1_n && !q_q.mr_prev[1]) begin
      q_d.endian = p.cfg.endian;
      q_d.bsize  = p.cfg.bsize;
    end
    if (p.cfg.mr2_n && !q_q.mr_prev[0]) begin
      q_d.endian = p.cfg.endian;
      q_d.csize  = p.cfg.csize;
    end

    // offsets from port A, parallel or serial
    if (a_wr && p.a.prog && !p.a.mail) begin
      q_d.ofs[p.a.prog_idx] = p.a.data[AW-1:0];
    end
    if (ea && p.a.ser_en) begin
      q_d.ofs = (`FTM_OFS_NUM*AW)'({q_q.ofs, p.a.ser_dat});
    end

    // port A long words into fifo1
    if (a_wr && !p.a.mail && !p.a.prog && q_q.room1 && run1) begin
      m1_we  = 1'b1;
      q_d.w1 = q_q.w1 + PW'(1);
    end

    // port B mail read frees mail A-to-B
    if (b_rd && p.b.mail) begin
      q_d.mab_full_n = 1'b1;
    end
    // port B unpacking of fifo1 long words
    if (b_rd && !p.b.mail) begin
      if (q_q.b_idx == 2'h0) begin
        if (cnt1 != PW'(0)) begin
          q_d.b_hold = mem1_rd;
          q_d.r1     = q_q.r1 + PW'(1);
          q_d.b_out  = pick(mem1_rd, q_q.bsize, q_q.endian, 2'h0);
          q_d.b_idx  = 2'h1;
        end
      end else begin
        q_d.b_out = pick(q_q.b_hold, q_q.bsize, q_q.endian, q_q.b_idx);
        q_d.b_idx = (q_q.b_idx == b_last) ? 2'h0 : q_q.b_idx + 2'h1;
      end
    end

    // port A mail write, dropped while occupied
    if (a_wr && p.a.mail && q_q.mab_full_n && run1) begin
      q_d.mab        = q_q.bsize ? {`FTM_BW_ZERO, p.a.data[`FTM_BW-1:0]}
                                 : p.a.data[`FTM_HW-1:0];
      q_d.mab_full_n = 1'b0;
    end

    // port A: mailbox read frees mail C-to-A
    if (a_rd && p.a.mail && run2) begin
      q_d.mca_full_n = 1'b1;
    end
    if (a_rd && !p.a.mail && run2 && cnt2 != PW'(0)) begin
      q_d.a_out = mem2_rd;
      q_d.r2    = q_q.r2 + PW'(1);
    end

    // port C mail write
    if (c_wr && p.c.mail && q_q.mca_full_n) begin
      q_d.mca        = q_q.csize ? {`FTM_BW_ZERO, p.c.data[`FTM_BW-1:0]} : p.c.data;
      q_d.mca_full_n = 1'b0;
    end
    // port C packing into fifo2
    if (c_wr && !p.c.mail && q_q.room2) begin
      if (q_q.c_idx == c_last) begin
        m2_we     = 1'b1;
        m2_wdata  = place(q_q.c_asm, p.c.data, q_q.csize, q_q.endian, q_q.c_idx);
        q_d.w2    = q_q.w2 + PW'(1);
        q_d.c_idx = 2'h0;
      end else begin
        q_d.c_asm = place(q_q.c_asm, p.c.data, q_q.csize, q_q.endian, q_q.c_idx);
        q_d.c_idx = q_q.c_idx + 2'h1;
      end
    end

    // master resets clear fifo and preset offsets
    if (!run1) begin
      q_d.w1         = '0;
      q_d.r1         = '0;
      q_d.b_idx      = 2'h0;
      q_d.mab_full_n = 1'b1;
      q_d.ofs[`FTM_OFS_E1] = AW'(PRESET);
      q_d.ofs[`FTM_OFS_F1] = AW'(PRESET);
    end
    if (!run2) begin
      q_d.w2         = '0;
      q_d.r2         = '0;
      q_d.c_idx      = 2'h0;
      q_d.mca_full_n = 1'b1;
      q_d.ofs[`FTM_OFS_E2] = AW'(PRESET);
      q_d.ofs[`FTM_OFS_F2] = AW'(PRESET);
    end
    q_d.room1 = run1 && ((q_d.w1 - q_d.r1) != PW'(DEPTH));
    q_d.room2 = run2 && ((q_d.w2 - q_d.r2) != PW'(DEPTH));

    // mail when selected, no endian on mail
    q_d.a_oe   = run2 & ~p.a.cs_n & ~p.a.dir;
    q_d.b_oe   = run1 & ~p.b.cs_n;
    q_d.a_dout = p.a.mail ? {q_d.mca, `FTM_HW_ZERO} : q_d.a_out;
    q_d.b_dout = p.b.mail ? q_d.mab : q_d.b_out;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q_q            <= '0;
      q_q.clk_prev   <= 3'h7;
      q_q.mab_full_n <= 1'b1;
      q_q.mca_full_n <= 1'b1;
      q_q.ofs        <= {`FTM_OFS_NUM{AW'(PRESET)}};
    end else begin
      q_q <= q_d;
    end
  end

  // mail registers sit in q_q, never in the arrays
  always_ff @(posedge i_clk) begin
    if (m1_we) begin
      mem1[q_q.w1[AW-1:0]] <= p.a.data;
    end
    if (m2_we) begin
      mem2[q_q.w2[AW-1:0]] <= m2_wdata;
    end
  end

  // 0: fifo1 empty side on B, 1: fifo2 empty side on A,
  // 2: fifo1 full side on A, 3: fifo2 full side on C
  always_comb begin
    flag_edge  = {p.c.clk & ~q_q.clk_prev[0], p.a.clk & ~q_q.clk_prev[2],
                  p.a.clk & ~q_q.clk_prev[2], p.b.clk & ~q_q.clk_prev[1]};
    flag_rst_n = {i_nrst & p.cfg.mr2_n, i_nrst & p.cfg.mr1_n,
                  i_nrst & p.cfg.mr2_n, i_nrst & p.cfg.mr1_n};
    flag_lvl[0] = cnt1 > PW'(q_q.ofs[`FTM_OFS_E1]);
    flag_lvl[1] = cnt2 > PW'(q_q.ofs[`FTM_OFS_E2]);
    flag_lvl[2] = cnt1 <= PW'(DEPTH) - PW'(q_q.ofs[`FTM_OFS_F1]) - PW'(1);
    flag_lvl[3] = cnt2 <= PW'(DEPTH) - PW'(q_q.ofs[`FTM_OFS_F2]) - PW'(1);
  end

  // two-edge flag pipelines
  for (genvar gi = 0; gi < 4; gi++) begin : g_flag
    ftm_flag_sync #(.RST_VAL(gi >= 2)) u_flag (
      .i_clk   (i_clk),
      .i_nrst  (flag_rst_n[gi]),
      .i_edge  (flag_edge[gi]),
      .i_level (flag_lvl[gi]),
      .o_flag  (flag_out[gi])
    );
  end

  assign o_fifo1_nearly_empty_flag = flag_out[0];
  assign o_fifo2_nearly_empty_flag = flag_out[1];
  assign o_fifo1_nearly_full_flag  = flag_out[2];
  assign o_fifo2_nearly_full_flag  = flag_out[3];
  assign o_fifo1_room_flag         = q_q.room1;
  assign o_fifo2_room_flag         = q_q.room2;
  assign o_mail_ab_full_n          = q_q.mab_full_n;
  assign o_mail_ca_full_n          = q_q.mca_full_n;
  assign o_port_a_data             = q_q.a_dout;
  assign o_port_a_data_oe          = q_q.a_oe;
  assign o_port_b_data             = q_q.b_dout;
  assign o_port_b_data_oe          = q_q.b_oe;

endmodule : ftm_fifo_pair

// *** src/ftm_flag_sync.sv ***
// Purpose: flag that follows its level after two port edges
// Assumes: i_edge pulses once per port clock rise
// Notes:   RST_VAL is the flag level during reset
`timescale 1ns/1ps

module ftm_flag_sync
  import ftm_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_edge,
  input  wire logic i_level,
  output logic      o_flag
);

  ftm_flag_s q_q;
  ftm_flag_s q_d;

  always_comb begin
    q_d = q_q;
    if (i_edge) begin
      q_d.stage = i_level;
      q_d.flag  = q_q.stage;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q_q.stage <= RST_VAL;
      q_q.flag  <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_flag = q_q.flag;

endmodule : ftm_flag_sync

// *** src/ftm_sync.sv ***
// Purpose: two-stage pin synchroniser
// Assumes: i_d is outside the i_clk domain
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps

module ftm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ftm_sync_s;

  ftm_sync_s q_q;
  ftm_sync_s q_d;

  always_comb begin
    q_d    = q_q;
    q_d.s1 = i_d;
    q_d.s2 = q_q.s1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_q = q_q.s2;

endmodule : ftm_sync

// *** verification/ftm_fifo_pair_assertions.sv ***
// Purpose: port checks of fifo pair flags and mail
// Assumes: port controls steady for 8 i_clk around port edges
// Notes:   bound into every ftm_fifo_pair
`timescale 1ns/1ps
`include "ftm_consts.svh"

module ftm_fifo_pair_assertions (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_port_a_chip_select_n,
  input  wire logic               i_port_a_direction,
  input  wire logic               i_port_a_mail_select,
  input  wire logic               i_port_b_chip_select_n,
  input  wire logic               i_port_b_mail_select,
  input  wire logic               i_port_c_write_strobe,
  input  wire logic               i_port_c_mail_select,
  input  wire logic               i_port_b_width_sel,
  input  wire logic               i_fifo1_master_reset_n,
  input  wire logic               i_fifo2_master_reset_n,
  input  wire logic [`FTM_LW-1:0] o_port_a_data,
  input  wire logic [`FTM_HW-1:0] o_port_b_data,
  input  wire logic               o_port_b_data_oe,
  input  wire logic               o_fifo1_nearly_empty_flag,
  input  wire logic               o_fifo2_nearly_empty_flag,
  input  wire logic               o_fifo1_nearly_full_flag,
  input  wire logic               o_fifo2_nearly_full_flag,
  input  wire logic               o_fifo1_room_flag,
  input  wire logic               o_fifo2_room_flag,
  input  wire logic               o_mail_ab_full_n,
  input  wire logic               o_mail_ca_full_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_mr1_flags;
    !i_fifo1_master_reset_n [*6] |->
      !o_fifo1_nearly_empty_flag && o_fifo1_nearly_full_flag && !o_fifo1_room_flag;
  endproperty
  a_mr1_flags: assert property (p_mr1_flags)
    else $error("fifo1 reset flags");

  property p_mr2_flags;
    !i_fifo2_master_reset_n [*6] |->
      !o_fifo2_nearly_empty_flag && o_fifo2_nearly_full_flag && !o_fifo2_room_flag;
  endproperty
  a_mr2_flags: assert property (p_mr2_flags)
    else $error("fifo2 reset flags");

  property p_b_byte;
    i_port_b_width_sel && o_port_b_data_oe |-> o_port_b_data[17:9] == 9'h000;
  endproperty
  a_b_byte: assert property (p_b_byte)
    else $error("port b upper lane");

  property p_a_mail_lanes;
    (i_port_a_mail_select && !i_port_a_chip_select_n && !i_port_a_direction) [*8]
      |=> o_port_a_data[17:0] == 18'h00000;
  endproperty
  a_a_mail_lanes: assert property (p_a_mail_lanes)
    else $error("port a low lanes");

  property p_ab_set;
    $fell(o_mail_ab_full_n) |-> $past(i_port_a_mail_select, 3) &&
      $past(i_port_a_direction, 3) && !$past(i_port_a_chip_select_n, 3);
  endproperty
  a_ab_set: assert property (p_ab_set)
    else $error("mail ab set unasked");

  property p_ab_clear;
    $rose(o_mail_ab_full_n) |->
      (!$past(i_port_b_chip_select_n, 3) && $past(i_port_b_mail_select, 3)) ||
      !$past(i_fifo1_master_reset_n, 2) || !$past(i_fifo2_master_reset_n, 2);
  endproperty
  a_ab_clear: assert property (p_ab_clear)
    else $error("mail ab freed unasked");

  property p_b_oe;
    i_port_b_chip_select_n [*6] |=> !o_port_b_data_oe;
  endproperty
  a_b_oe: assert property (p_b_oe)
    else $error("port b driven idle");

  property p_ca_set;
    $fell(o_mail_ca_full_n) |->
      $past(i_port_c_mail_select, 3) && $past(i_port_c_write_strobe, 3);
  endproperty
  a_ca_set: assert property (p_ca_set)
    else $error("mail ca set unasked");
endmodule : ftm_fifo_pair_assertions

bind ftm_fifo_pair ftm_fifo_pair_assertions i_chk (.*);

// *** verification/ftm_port_masters.sv ***
// Purpose: free-running port clocks
// Assumes: 160 ns period, phases unrelated to i_clk
// Notes:   transfers come from bench tasks
`timescale 1ns/1ps

module ftm_port_masters (
  output logic o_a_clk,
  output logic o_b_clk,
  output logic o_c_clk
);
  initial begin
    o_a_clk = 1'b0;
    o_b_clk = 1'b0;
    o_c_clk = 1'b0;
    fork
      #13 forever #80 o_a_clk = ~o_a_clk;
      #47 forever #80 o_b_clk = ~o_b_clk;
      #71 forever #80 o_c_clk = ~o_c_clk;
    join
  end
endmodule : ftm_port_masters

// *** verification/test_triple_port_fifo_flags_mailbox.sv ***
// Purpose: self-checking fifo pair bench
// Assumes: controls change just after a port clock falls
// Notes:   DEPTH shrunk to 64 for run time
`timescale 1ns/1ps

module test_triple_port_fifo_flags_mailbox;
  import ftm_pkg::*;
  typedef struct packed {
    logic w; logic be; logic [35:0] a; logic [17:0] c; logic [17:0] eb; logic [17:0] ea;
  } ftm_row_s;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_port_a_clock, i_port_b_clock, i_port_c_clock;
  logic i_port_a_chip_select_n = 1'b1, i_port_a_direction = 1'b0, i_port_a_strobe_on = 1'b0;
  logic i_port_a_mail_select = 1'b0, i_port_a_prog_enable = 1'b0;
  logic i_serial_enable = 1'b0, i_serial_data = 1'b0;
  logic i_port_b_chip_select_n = 1'b1, i_port_b_read_strobe = 1'b0, i_port_b_mail_select = 1'b0;
  logic i_port_c_write_strobe = 1'b0, i_port_c_mail_select = 1'b1, i_endian_select = 1'b0;
  logic i_port_b_width_sel = 1'b0, i_port_c_width_sel = 1'b0;
  logic i_fifo1_master_reset_n = 1'b1, i_fifo2_master_reset_n = 1'b1;
  logic [1:0]  i_port_a_prog_index = 2'h0;
  logic [35:0] i_port_a_data = 36'h0, o_port_a_data;
  logic [17:0] i_port_c_data = 18'h0, o_port_b_data;
  logic o_port_a_data_oe, o_port_b_data_oe, o_mail_ab_full_n, o_mail_ca_full_n;
  logic o_fifo1_nearly_empty_flag, o_fifo2_nearly_empty_flag, o_fifo1_room_flag;
  logic o_fifo1_nearly_full_flag, o_fifo2_nearly_full_flag, o_fifo2_room_flag;
  wire  [2:0] pclk = {i_port_c_clock, i_port_b_clock, i_port_a_clock};
  int miscompares = 0, tests_run = 0, cycles = 0;
  ftm_row_s rows [4] = '{
    '{1'b0, 1'b1, 36'hABCDE1234, 18'h2F00F, 18'h21234, 18'h2F00F},
    '{1'b0, 1'b0, 36'h00003FFFF, 18'h15A5A, 18'h3FFFF, 18'h15A5A},
    '{1'b1, 1'b1, 36'hFFFFFFE55, 18'h3FF81, 18'h00055, 18'h00181},
    '{1'b1, 1'b0, 36'h0000001AA, 18'h001C3, 18'h001AA, 18'h001C3}};

  ftm_port_masters i_pm (.o_a_clk(i_port_a_clock), .o_b_clk(i_port_b_clock),
                         .o_c_clk(i_port_c_clock));
  ftm_fifo_pair #(.DEPTH(64), .PRESET(8)) i_dut (.*);

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic pw(input int p, input logic v);
    @(posedge i_clk);
    while (pclk[p] !== v) @(posedge i_clk);
  endtask : pw

  // start just after a port fall; finish 8 cycles past the rise
  task automatic go(input int p);
    pw(p, 1'b1);
    pw(p, 1'b0);
  endtask : go

  task automatic fin(input int p);
    pw(p, 1'b1);
    repeat (8) @(posedge i_clk);
  endtask : fin

  task automatic opa(input logic w, input logic m, input logic p, input logic [35:0] d);
    go(0);
    i_port_a_chip_select_n <= 1'b0;
    i_port_a_direction     <= w;
    i_port_a_strobe_on     <= 1'b1;
    i_port_a_mail_select   <= m;
    i_port_a_prog_enable   <= p;
    i_port_a_data          <= d;
    fin(0);
  endtask : opa

  task automatic opb(input logic m);
    go(1);
    i_port_b_chip_select_n <= 1'b0;
    i_port_b_read_strobe   <= 1'b1;
    i_port_b_mail_select   <= m;
    fin(1);
  endtask : opb

  task automatic opc(input logic m, input logic [17:0] d);
    go(2);
    i_port_c_write_strobe <= 1'b1;
    i_port_c_mail_select  <= m;
    i_port_c_data         <= d;
    fin(2);
  endtask : opc

  task automatic rel();
    @(posedge i_clk);
    i_port_a_chip_select_n <= 1'b1;
    i_port_a_strobe_on     <= 1'b0;
    i_port_a_mail_select   <= 1'b0;
    i_port_a_prog_enable   <= 1'b0;
    i_port_b_chip_select_n <= 1'b1;
    i_port_b_read_strobe   <= 1'b0;
    i_port_b_mail_select   <= 1'b0;
    i_port_c_write_strobe  <= 1'b0;
    i_port_c_mail_select   <= 1'b0;
  endtask : rel

  task automatic mrs(input logic w, input logic be);
    @(posedge i_clk);
    i_fifo1_master_reset_n <= 1'b0;
    i_fifo2_master_reset_n <= 1'b0;
    i_port_c_mail_select   <= 1'b1;
    i_port_b_width_sel     <= w;
    i_port_c_width_sel     <= w;
    i_endian_select        <= be;
    repeat (20) @(posedge i_clk);
    i_fifo1_master_reset_n <= 1'b1;
    i_fifo2_master_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk(36'({o_fifo1_room_flag, o_fifo2_room_flag}), 36'h3);
    repeat (64) @(posedge i_clk);
    i_port_c_mail_select <= 1'b0;
  endtask : mrs

  task automatic end_sim();
    $display("tests %0d errors %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rows[i]) begin
      mrs(rows[i].w, rows[i].be);
      opa(1'b1, 1'b1, 1'b0, rows[i].a);
      chk(36'(o_mail_ab_full_n), 36'h0);
      rel();
      opb(1'b1);
      chk(36'(o_port_b_data), 36'(rows[i].eb));
      chk(36'(o_mail_ab_full_n), 36'h1);
      rel();
      opc(1'b1, rows[i].c);
      chk(36'(o_mail_ca_full_n), 36'h0);
      rel();
      opa(1'b0, 1'b1, 1'b0, 36'h0);
      chk(o_port_a_data, {rows[i].ea, 18'h00000});
      chk(36'(o_mail_ca_full_n), 36'h1);
      rel();
    end
    // mail write while full is dropped; reads keep data
    mrs(1'b0, 1'b1);
    opa(1'b1, 1'b1, 1'b0, 36'h000011111);
    rel();
    opa(1'b1, 1'b1, 1'b0, 36'h000022222);
    rel();
    opb(1'b1);
    rel();
    opb(1'b1);
    chk(36'(o_port_b_data), 36'h11111);
    rel();
    // fifo2 empty offset 0, one long word of two big-endian words
    i_port_a_prog_index <= 2'h1;
    opa(1'b1, 1'b0, 1'b1, 36'h0);
    rel();
    opc(1'b0, 18'h12345);
    rel();
    opc(1'b0, 18'h0ABCD);
    rel();
    @(posedge i_port_a_clock);
    repeat (8) @(posedge i_clk);
    chk(36'(o_fifo2_nearly_empty_flag), 36'h0);
    @(posedge i_port_a_clock);
    repeat (8) @(posedge i_clk);
    chk(36'(o_fifo2_nearly_empty_flag), 36'h1);
    opa(1'b0, 1'b0, 1'b0, 36'h0);
    chk(o_port_a_data, {18'h12345, 18'h0ABCD});
    rel();
    // fifo1 long word out as two big-endian words
    opa(1'b1, 1'b0, 1'b0, {18'h261D9, 18'h14321});
    rel();
    repeat (3) @(posedge i_port_b_clock);
    chk(36'({o_port_a_data_oe, o_fifo1_nearly_empty_flag, o_fifo1_nearly_full_flag,
             o_fifo2_nearly_full_flag}), 36'h3);
    opb(1'b0);
    chk(36'(o_port_b_data), 36'h261D9);
    rel();
    opb(1'b0);
    chk(36'(o_port_b_data), 36'h14321);
    rel();
    end_sim();
  end
endmodule : test_triple_port_fifo_flags_mailbox
